/* sincos_interp_defs.vh */
// Purpose: Shared constants of the sine/cosine interpolation datapath.
// Assumes: Included by bare name from the design files.
// Notes: Table memory words are 12 bits wide; narrower entries sit in the low bits.
`ifndef SINCOS_INTERP_DEFS_VH
`define SINCOS_INTERP_DEFS_VH
`define NUM_MOTORS 4
`define ADC_W 6
`define ANGLE_W 12
`define ANGLE_COUNTS 4096
`define INTERP_GAIN 1024
`define CNT_W 32
`define POS_W 42
`define TBL_AW 13
`define TBL_DW 12
`define TBL_WORDS 4608
`define ATAN_BASE 13'h0000
`define COMP_BASE 13'h1000
`define COMP_STRIDE 13'h0080
`define COS_OFS 13'h0040
`define COMP_SPAN 13'h0080
`define SCOPE_ALL 1'b0
`define SCOPE_MOTOR 1'b1
`define FIFO_DEPTH 16
`define MIN_CAL_SAMPLES 50
`endif

/* wr_fifo.v */
// Purpose: Buffer between the host table-write stream and the table memory.
// Assumes: One clock; the reader may stall at will.
// Notes: Full and empty are exact; one push and one pop may occur in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module wr_fifo #(
   parameter WIDTH = 25,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire ref_clk,
   input wire rst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] store [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] fill_r;
   reg ready_r;
   wire push;
   wire pop;

   // Ready is a flop, so fullness is worked out one step ahead from the fill change.
   assign in_ready = ready_r;
   assign out_valid = (fill_r != {(AW+1){1'b0}});
   assign out_data = store[rd_ptr_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge ref_clk) begin
      if (push) begin
         store[wr_ptr_r] <= in_data;
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         fill_r <= {(AW+1){1'b0}};
         ready_r <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            fill_r <= fill_r + 1'b1;
            ready_r <= (fill_r != DEPTH[AW:0] - 1'b1);
         end else if (pop && !push) begin
            fill_r <= fill_r - 1'b1;
            ready_r <= 1'b1;
         end
      end
   end
endmodule // wr_fifo
`default_nettype wire

/* sincos_interp.v */
// Purpose: Per-motor sine/cosine interpolation with compensation and arctangent lookup.
// Assumes: Converter codes and the sample strobe come from ref_clk logic; quadrature pins are asynchronous.
// Notes: The table memory has no reset so that its contents survive any reset.
// Contract
// [R1] Interpolated position is 1024 times quadrature resolution.
// [R2] Sine and cosine sampled at one instant.
// [R3] Compensate raw samples before angle lookup.
// [R4] Angle comes from arctangent table, corrected index.
// [R5] Compensation removes offset and equalises amplitude.
// [R6] Separate sine and cosine tables per motor.
// [R7] Memory split: arctangent region, per-motor regions.
// [R8] Table contents survive reset and power loss; the array here has no reset but is not kept over power loss.
// [R9] One sine and cosine sample per servo cycle.
// [R10] Host calibration move gives fifty samples per period.
// [R11] Host unity table passes raw input through.
// [R12] Write whole memory or one motor's pair.
// [R13] Host may read back the whole memory.
// [R14] Position is quadrant count/4 joined with 12-bit angle.
// [R15] Each motor interpolated or plain quadrature count.
// [R16] Cosine wired to input A, sine to B.
// [R17] Compensation table indexed by raw code, output used.
// [R18] No partial tables used; position invalid meanwhile.
`timescale 1ns/1ns
`default_nettype none
`include "sincos_interp_defs.vh"
module sincos_interp #(
   parameter NM = `NUM_MOTORS,
   parameter ADC_W = `ADC_W,
   parameter CNT_W = `CNT_W,
   parameter POS_W = `POS_W
) (
   input wire ref_clk,
   input wire rst_n,
   input wire sample_strobe,
   input wire [NM*ADC_W-1:0] adc_sin,
   input wire [NM*ADC_W-1:0] adc_cos,
   input wire [NM-1:0] quad_in_a,
   input wire [NM-1:0] quad_in_b,
   input wire [NM-1:0] interp_en,
   input wire [1:0] rec_motor,
   output reg [ADC_W-1:0] rec_sin_r,
   output reg [ADC_W-1:0] rec_cos_r,
   output reg rec_valid_r,
   input wire load_start,
   input wire load_scope,
   input wire [1:0] load_motor,
   input wire load_end,
   output reg load_busy_r,
   input wire wr_valid,
   output wire wr_ready,
   input wire [`TBL_AW-1:0] wr_addr,
   input wire [`TBL_DW-1:0] wr_data,
   input wire rd_req,
   input wire [`TBL_AW-1:0] rd_addr,
   output reg [`TBL_DW-1:0] rd_data_r,
   output reg rd_valid_r,
   output reg [NM*POS_W-1:0] pos_r,
   output reg [NM-1:0] pos_valid_r
);
   localparam S_IDLE = 3'd0;
   localparam S_SIN = 3'd1;
   localparam S_COS = 3'd2;
   localparam S_ATAN = 3'd3;
   localparam S_POS = 3'd4;

   reg [`TBL_DW-1:0] mem [0:`TBL_WORDS-1];
   reg [`TBL_DW-1:0] mem_q;
   reg [2:0] state_r;
   reg [1:0] idx_r;
   reg [NM*ADC_W-1:0] sin_s_r;
   reg [NM*ADC_W-1:0] cos_s_r;
   reg [ADC_W-1:0] sin_c_r;
   reg scope_r;
   reg [1:0] scope_motor_r;
   reg closing_r;
   reg rd_busy_r;
   reg rd_to_out_r;
   reg [`TBL_AW-1:0] raddr;
   wire [NM*CNT_W-1:0] cnt_w;
   wire f_valid;
   wire [`TBL_AW+`TBL_DW-1:0] f_data;
   wire [`TBL_AW-1:0] f_addr;
   wire [`TBL_AW-1:0] region_lo;
   wire in_region;
   wire drain;
   wire rd_serve;
   wire [`TBL_AW-1:0] comp_base;
   wire [CNT_W-1:0] cnt_sel;
   wire [ADC_W-1:0] sin_raw;
   wire [ADC_W-1:0] cos_raw;

   // Host writes are buffered; the drain stalls while a read-back owns the memory port.
   wr_fifo #(.WIDTH(`TBL_AW+`TBL_DW), .DEPTH(`FIFO_DEPTH), .AW(4)) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(wr_valid & load_busy_r),
      .in_ready(wr_ready),
      .in_data({wr_addr, wr_data}),
      .out_valid(f_valid),
      .out_ready(load_busy_r & ~rd_serve),
      .out_data(f_data)
   );

   assign f_addr = f_data[`TBL_AW+`TBL_DW-1:`TBL_DW];
   assign drain = f_valid & load_busy_r & ~rd_serve;
   assign region_lo = `COMP_BASE + {scope_motor_r, 7'h00};
   // A motor-scoped load only touches that motor's sine/cosine pair.
   assign in_region = (scope_r == `SCOPE_ALL) ||
      (f_addr >= region_lo && f_addr < region_lo + `COMP_SPAN); // [R12]
   // One read in flight: every stage of the read pipe blocks a new serve.
   assign rd_serve = rd_req & (state_r == S_IDLE) & ~sample_strobe & ~rd_busy_r & ~rd_to_out_r & ~rd_valid_r; // [R13]
   assign comp_base = `COMP_BASE + {idx_r, 7'h00}; // [R6] [R7]
   assign cnt_sel = cnt_w[idx_r*CNT_W +: CNT_W];
   assign sin_raw = sin_s_r[idx_r*ADC_W +: ADC_W];
   assign cos_raw = cos_s_r[idx_r*ADC_W +: ADC_W];

   // Quadrature counting with three-stage synchronisers; cosine is A, sine is B.
   genvar g;
   generate
      for (g = 0; g < NM; g = g + 1) begin : g_quad
         reg [2:0] sa_r;
         reg [2:0] sb_r;
         reg [1:0] ab_r;
         reg [CNT_W-1:0] cnt_r;
         wire [1:0] ab_new;
         assign ab_new = {(sa_r[1] == sa_r[2]) ? sa_r[1] : ab_r[1], (sb_r[1] == sb_r[2]) ? sb_r[1] : ab_r[0]};
         assign cnt_w[g*CNT_W +: CNT_W] = cnt_r;
         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               sa_r <= 3'h0;
               sb_r <= 3'h0;
               ab_r <= 2'h0;
               cnt_r <= {CNT_W{1'b0}};
            end else begin
               sa_r <= {sa_r[1:0], quad_in_a[g]}; // [R16]
               sb_r <= {sb_r[1:0], quad_in_b[g]};
               ab_r <= ab_new;
               // Gray step forward: 00-01-11-10 on (A,B) with B leading.
               if ({ab_r, ab_new} == 4'h1 || {ab_r, ab_new} == 4'h7 || {ab_r, ab_new} == 4'hE ||
                   {ab_r, ab_new} == 4'h8) begin
                  cnt_r <= cnt_r + 1'b1;
               end else if ({ab_r, ab_new} == 4'h4 || {ab_r, ab_new} == 4'hD || {ab_r, ab_new} == 4'hB ||
                            {ab_r, ab_new} == 4'h2) begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
         end
      end
   endgenerate

   always @* begin
      raddr = rd_addr;
      case (state_r)
         S_SIN: raddr = comp_base + {{(`TBL_AW-ADC_W){1'b0}}, sin_raw}; // [R17]
         S_COS: raddr = comp_base + `COS_OFS + {{(`TBL_AW-ADC_W){1'b0}}, cos_raw}; // [R17]
         S_ATAN: raddr = `ATAN_BASE + {1'b0, sin_c_r, mem_q[ADC_W-1:0]}; // [R3] [R4]
         default: raddr = rd_addr;
      endcase
   end

   // No reset on the table array: its contents must outlive every reset.
   always @(posedge ref_clk) begin
      if (drain && in_region) begin
         mem[f_addr] <= f_data[`TBL_DW-1:0]; // [R8] [R12]
      end
      mem_q <= mem[raddr];
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_IDLE;
         idx_r <= 2'h0;
         sin_s_r <= {(NM*ADC_W){1'b0}};
         cos_s_r <= {(NM*ADC_W){1'b0}};
         sin_c_r <= {ADC_W{1'b0}};
         rec_sin_r <= {ADC_W{1'b0}};
         rec_cos_r <= {ADC_W{1'b0}};
         rec_valid_r <= 1'b0;
         load_busy_r <= 1'b0;
         scope_r <= `SCOPE_ALL;
         scope_motor_r <= 2'h0;
         closing_r <= 1'b0;
         rd_busy_r <= 1'b0;
         rd_to_out_r <= 1'b0;
         rd_data_r <= {`TBL_DW{1'b0}};
         rd_valid_r <= 1'b0;
         pos_r <= {(NM*POS_W){1'b0}};
         pos_valid_r <= {NM{1'b0}};
      end else begin
         rec_valid_r <= 1'b0;
         rd_busy_r <= rd_serve;
         rd_to_out_r <= rd_busy_r;
         rd_valid_r <= rd_to_out_r;
         if (rd_to_out_r) begin
            rd_data_r <= mem_q;
         end
         // Load session: position is withheld from start until the buffer is flushed.
         if (load_start && !load_busy_r) begin
            load_busy_r <= 1'b1;
            scope_r <= load_scope;
            scope_motor_r <= load_motor;
            closing_r <= 1'b0;
            pos_valid_r <= {NM{1'b0}}; // [R18]
         end else if (load_busy_r) begin
            if (load_end) begin
               closing_r <= 1'b1;
            end
            if ((closing_r || load_end) && !f_valid && !wr_valid) begin
               load_busy_r <= 1'b0;
            end
         end
         if (sample_strobe) begin
            rec_sin_r <= adc_sin[rec_motor*ADC_W +: ADC_W]; // [R9]
            rec_cos_r <= adc_cos[rec_motor*ADC_W +: ADC_W]; // [R9]
            rec_valid_r <= 1'b1; // [R9]
         end
         case (state_r)
            S_IDLE: begin
               // A strobe during a pass is ignored; a pass takes 4 cycles per motor.
               if (sample_strobe && !load_busy_r && !load_start) begin
                  // Samples freeze only when a pass starts, so a strobe mid-pass cannot split a pair.
                  sin_s_r <= adc_sin; // [R2]
                  cos_s_r <= adc_cos; // [R2]
                  idx_r <= 2'h0;
                  state_r <= S_SIN;
               end
            end
            S_SIN: begin
               state_r <= S_COS;
            end
            S_COS: begin
               sin_c_r <= mem_q[ADC_W-1:0]; // [R5]
               state_r <= S_ATAN;
            end
            S_ATAN: begin
               state_r <= S_POS;
            end
            S_POS: begin
               if (interp_en[idx_r]) begin
                  pos_r[idx_r*POS_W +: POS_W] <= {cnt_sel[CNT_W-1:2], mem_q[`ANGLE_W-1:0]}; // [R1] [R14] [R15]
               end else begin
                  pos_r[idx_r*POS_W +: POS_W] <= {{(POS_W-CNT_W){cnt_sel[CNT_W-1]}}, cnt_sel}; // [R15]
               end
               // A session opening on this very edge must win over the pass's valid.
               pos_valid_r[idx_r] <= ~(load_busy_r | load_start); // [R18]
               if (idx_r == NM[1:0] - 2'd1 || load_busy_r) begin
                  state_r <= S_IDLE;
               end else begin
                  idx_r <= idx_r + 2'd1;
                  state_r <= S_SIN;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end
endmodule // sincos_interp
`default_nettype wire

/* sincos_interp_chk.sv */
// Purpose: Concurrent checks on the interpolation datapath ports.
// Assumes: Bound to sincos_interp.
// Notes: Pass timing is checked on motor 0.
`timescale 1ns/1ns
`default_nettype none
module sincos_interp_chk #(
   parameter NM = 4,
   parameter ADC_W = 6
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sample_strobe,
   input wire logic [NM*ADC_W-1:0] adc_sin,
   input wire logic [NM*ADC_W-1:0] adc_cos,
   input wire logic [1:0] rec_motor,
   input wire logic [ADC_W-1:0] rec_sin_r,
   input wire logic [ADC_W-1:0] rec_cos_r,
   input wire logic rec_valid_r,
   input wire logic load_start,
   input wire logic load_busy_r,
   input wire logic rd_req,
   input wire logic rd_valid_r,
   input wire logic [NM-1:0] pos_valid_r
);
   wire logic [2*ADC_W-1:0] sel = {adc_sin[rec_motor*ADC_W +: ADC_W], adc_cos[rec_motor*ADC_W +: ADC_W]};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   AST_REC: assert property (sample_strobe |=> rec_valid_r) else $error("record pulse missing");
   AST_REC_ONE: assert property (!sample_strobe |=> !rec_valid_r) else $error("stray record pulse");
   AST_REC_DATA: assert property (sample_strobe |=> {rec_sin_r, rec_cos_r} == $past(sel))
      else $error("recorded pair wrong");
   AST_BUSY_SET: assert property (load_start && !load_busy_r |=> load_busy_r) else $error("no session");
   AST_BUSY_WHY: assert property ($rose(load_busy_r) |-> $past(load_start)) else $error("busy uncaused");
   AST_INVALID: assert property (load_busy_r |-> pos_valid_r == '0) else $error("valid in session");
   AST_RD_LAT: assert property (rd_valid_r |-> $past(rd_req, 3)) else $error("read latency wrong");
   AST_RD_ONE: assert property (rd_valid_r |=> !rd_valid_r) else $error("read pulse too long");
   AST_POS_AT: assert property ($rose(pos_valid_r[0]) |-> $past(sample_strobe, 5))
      else $error("motor 0 update late");
endmodule // sincos_interp_chk
bind sincos_interp sincos_interp_chk #(.NM(NM), .ADC_W(ADC_W)) sincos_interp_chk_i (.ref_clk(ref_clk),
   .rst_n(rst_n), .sample_strobe(sample_strobe), .adc_sin(adc_sin), .adc_cos(adc_cos), .rec_motor(rec_motor),
   .rec_sin_r(rec_sin_r), .rec_cos_r(rec_cos_r), .rec_valid_r(rec_valid_r), .load_start(load_start),
   .load_busy_r(load_busy_r), .rd_req(rd_req), .rd_valid_r(rd_valid_r), .pos_valid_r(pos_valid_r));
`default_nettype wire

/* scale_model.sv */
// Purpose: Quadrature side of an analog scale moving forward.
// Assumes: Each rising step is one quadrant.
// Notes: All four motors share one scale so every counter sees motion.
`timescale 1ns/1ns
`default_nettype none
module scale_model (
   input wire logic step,
   output logic [3:0] qa,
   output logic [3:0] qb
);
   logic [1:0] ph = 2'h0;
   always @(posedge step) ph <= ph + 2'h1;
   assign qa = {4{ph[1]}};
   assign qb = {4{ph[1] ^ ph[0]}};
endmodule // scale_model
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for the interpolation datapath.
// Assumes: Table memory starts unknown, so the first scenario loads it.
// Notes: Arctangent word equals its index, making angles easy to predict.
`timescale 1ns/1ns
`default_nettype none
`include "sincos_interp_defs.vh"
module tb_top;
   logic ref_clk = 1'b0, rst_n = 1'b0, sample_strobe = 1'b0, load_start = 1'b0, load_scope = 1'b0;
   logic load_end = 1'b0, wr_valid = 1'b0, rd_req = 1'b0, step = 1'b0;
   logic [23:0] adc_sin = 24'h9A5C3E, adc_cos = 24'h1F60B7;
   logic [3:0] interp_en = 4'hF;
   logic [1:0] rec_motor = 2'h2, load_motor = 2'h2;
   logic [12:0] wr_addr = 13'h0000, rd_addr = 13'h0000;
   logic [11:0] wr_data = 12'h000;
   wire [3:0] qa, qb, pos_valid_r;
   wire [5:0] rec_sin_r, rec_cos_r;
   wire rec_valid_r, load_busy_r, wr_ready, rd_valid_r;
   wire [11:0] rd_data_r;
   wire [167:0] pos_r;
   int n_mismatch = 0, tests_run = 0, cycles = 0;
   sincos_interp sincos_interp_i (.ref_clk(ref_clk), .rst_n(rst_n), .sample_strobe(sample_strobe),
      .adc_sin(adc_sin), .adc_cos(adc_cos), .quad_in_a(qa), .quad_in_b(qb), .interp_en(interp_en),
      .rec_motor(rec_motor), .rec_sin_r(rec_sin_r), .rec_cos_r(rec_cos_r), .rec_valid_r(rec_valid_r),
      .load_start(load_start), .load_scope(load_scope), .load_motor(load_motor), .load_end(load_end),
      .load_busy_r(load_busy_r), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .pos_r(pos_r),
      .pos_valid_r(pos_valid_r));
   scale_model scale_model_i (.step(step), .qa(qa), .qb(qb));
   initial forever #5 ref_clk = ~ref_clk;
   task test_done;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         n_mismatch = n_mismatch + 1;
         test_done;
      end
   end
   task check(input logic [41:0] seen, input logic [41:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("unexpected at %0t: saw %0h wanted %0h", $time, seen, exp);
      end
   endtask
   task tick;
      @(negedge ref_clk);
   endtask
   function automatic logic [11:0] ang(input int m, input logic inv);
      logic [5:0] s, c;
      s = adc_sin[m*6 +: 6] ^ {6{inv}};
      c = adc_cos[m*6 +: 6] ^ {6{inv}};
      return {s, c};
   endfunction
   task start(input logic scope);
      load_scope = scope;
      load_start = 1'b1;
      tick;
      load_start = 1'b0;
      check(load_busy_r, 1'b1);
      check(pos_valid_r, 4'h0);
      check(wr_ready, 1'b1);
   endtask
   task wr(input logic [12:0] a, input logic [11:0] d);
      wr_valid = 1'b1;
      wr_addr = a;
      wr_data = d;
      while (wr_ready !== 1'b1) tick;
      tick;
   endtask
   task close;
      int j;
      wr_valid = 1'b0;
      load_end = 1'b1;
      tick;
      load_end = 1'b0;
      for (j = 0; j < 40 && load_busy_r !== 1'b0; j++) tick;
      check(load_busy_r, 1'b0);
   endtask
   task pass;
      sample_strobe = 1'b1;
      tick;
      sample_strobe = 1'b0;
      repeat (20) tick;
   endtask
   task rd(input logic [12:0] a, input logic [11:0] exp);
      int j;
      rd_req = 1'b1;
      rd_addr = a;
      for (j = 0; j < 10 && rd_valid_r !== 1'b1; j++) tick;
      check(rd_valid_r, 1'b1);
      check(rd_data_r, exp);
      // The request stands through the edge that sees the answer and drops before a second serve.
      tick;
      rd_req = 1'b0;
      tick;
   endtask
   task t_full;
      int i;
      start(1'b0);
      for (i = 0; i < 4096; i++) wr(i[12:0], i[11:0]);
      // Unity compensation: each word returns its own raw code.
      for (i = 0; i < 512; i++) wr(`COMP_BASE + i[12:0], {6'h00, i[5:0]});
      close;
      pass;
      for (i = 0; i < 4; i++) begin
         check(pos_r[i*42 +: 42], {30'h0, ang(i, 1'b0)});
         check(pos_valid_r[i], 1'b1);
      end
   endtask
   task t_motor;
      int i;
      start(1'b1);
      for (i = 0; i < 128; i++) wr(`COMP_BASE + 2 * `COMP_STRIDE + i[12:0], {6'h00, ~i[5:0]});
      wr(13'h0003, 12'hFFF);
      close;
      pass;
      for (i = 0; i < 4; i++) check(pos_r[i*42 +: 42], {30'h0, ang(i, i == 2)});
      rd(13'h0003, 12'h003);
      rd(`COMP_BASE + 2 * `COMP_STRIDE + `COS_OFS + 13'h0005, 12'h03A);
   endtask
   task t_quad;
      interp_en = 4'h5;
      repeat (4) begin
         step = 1'b1;
         repeat (6) tick;
         step = 1'b0;
         repeat (6) tick;
      end
      pass;
      check(pos_r[0 +: 42], 42'h1000 + ang(0, 1'b0));
      check(pos_r[42 +: 42], 42'h4);
      check(pos_r[126 +: 42], 42'h4);
      check(pos_r[84 +: 42], 42'h1000 + ang(2, 1'b1));
   endtask
   task t_rec;
      int i;
      rec_motor = 2'h1;
      // A slow calibration sweep: the minimum number of samples inside one signal period.
      for (i = 0; i < `MIN_CAL_SAMPLES; i++) begin
         adc_sin[11:6] = i[5:0];
         adc_cos[11:6] = 6'h3F - i[5:0];
         sample_strobe = 1'b1;
         tick;
         sample_strobe = 1'b0;
         check(rec_valid_r, 1'b1);
         check({rec_sin_r, rec_cos_r}, {i[5:0], 6'h3F - i[5:0]});
         tick;
         check(rec_valid_r, 1'b0);
      end
      repeat (20) tick;
   endtask
   task t_reset;
      rst_n = 1'b0;
      interp_en = 4'hF;
      tick;
      check(pos_valid_r, 4'h0);
      rst_n = 1'b1;
      tick;
      pass;
      check(pos_r[0 +: 42], {30'h0, ang(0, 1'b0)});
      check(pos_r[84 +: 42], {30'h0, ang(2, 1'b1)});
   endtask
   initial begin
      repeat (10) tick;
      rst_n = 1'b1;
      tick;
      t_full;
      t_motor;
      t_quad;
      t_rec;
      t_reset;
      test_done;
   end
endmodule // tb_top
`default_nettype wire
